// ### design/gcsr_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Compare flag off: irq and pulse undriven
// - Compare flag on: drive pulse and irq
// - Probe flag routes test signal onto pin
// - Probe select picks routed internal signal
// - Motor 1 invert flag reverses direction
// - Motor 2 invert flag reverses direction
// - Lock bit blocks later flag writes
// - Status bit 0 shows reset since read
// - Reset flag comes with all registers reset
// - Driver 1 shutdown sets its fault flag
// - Driver 2 shutdown sets its fault flag
// - Read clears fault only once condition gone
// - Pump undervoltage flagged, drivers disabled meanwhile
// - Readback bit 7 mirrors disable pin
// - Readback top byte holds revision code
// - Match register compared with motor 1 position
// - Equal positions drive pulse high
// - Mismatch returns pulse low
// - Write address is offset plus 0x80
// - Registers power up as zero unless noted
// - Compared position is signed motor 1 position
module gcsr_regs (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic REG_STROBE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    input wire logic signed [31:0] CUR_POS,
    input wire logic EVENT_IRQ_IN,
    output logic EVENT_IRQ_OUT,
    output logic EVENT_IRQ_OE_N,
    output logic POS_PULSE_OUT,
    output logic POS_PULSE_OE_N,
    input wire logic [gcsr_pkg::PROBE_SRC_W-1:0] PROBE_SRC,
    input wire logic REF_SW_R2_IN,
    output logic REF_SW_R2_OUT,
    output logic REF_SW_R2_OE_N,
    output logic REF_SW_R2_LEVEL,
    input wire logic MOTOR1_DIR_IN,
    input wire logic MOTOR2_DIR_IN,
    output logic MOTOR1_DIR,
    output logic MOTOR2_DIR,
    input wire logic DRV1_SHUTDOWN,
    input wire logic DRV2_SHUTDOWN,
    input wire logic PUMP_UV_IN,
    input wire logic DRV_DISABLE_PIN,
    output logic DRIVERS_ENABLE,
    output logic [gcsr_pkg::FLAGS_W-1:0] GLOBAL_FLAGS
);
    import gcsr_pkg::*;

    logic [FLAGS_W-1:0] flags;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] next_status;
    logic [PROBE_W-1:0] probe_sel;
    logic [31:0] match_val;
    logic [2:0] uv_sync;
    logic [2:0] dis_sync;
    logic pump_uv;
    logic dis_level;
    logic wr;
    logic rd;
    logic [6:0] offs;
    logic [2:0] ref_sync;
    logic ref_level;
    logic pos_hit;

    // Two flops agreeing decide a level; glitches shorter than that vanish
    function automatic logic settle(input logic [2:0] s, input logic cur);
        settle = (s[1] == s[2]) ? s[1] : cur;
    endfunction : settle

    assign wr = REG_STROBE && REG_ADDR[WRITE_BIT];
    assign rd = REG_STROBE && !REG_ADDR[WRITE_BIT];
    assign offs = REG_ADDR[6:0];
    // Equality is sign agnostic, so the signed view costs nothing
    assign pos_hit = (CUR_POS == $signed(match_val));

    // Asynchronous pins
    always_ff @(posedge MCLK) begin
        if (RST) begin
            uv_sync <= 3'h0;
            dis_sync <= 3'h0;
            ref_sync <= 3'h0;
            pump_uv <= 1'b0;
            dis_level <= 1'b0;
            ref_level <= 1'b0;
        end else begin
            uv_sync <= {uv_sync[1:0], PUMP_UV_IN};
            dis_sync <= {dis_sync[1:0], DRV_DISABLE_PIN};
            ref_sync <= {ref_sync[1:0], REF_SW_R2_IN};
            pump_uv <= settle(uv_sync, pump_uv);
            dis_level <= settle(dis_sync, dis_level);
            ref_level <= settle(ref_sync, ref_level);
        end
    end

    // Global flags
    always_ff @(posedge MCLK) begin
        if (RST) begin
            flags <= FLAGS_RST;
        end else if (wr && offs == ADDR_GLOBAL_FLAGS && !flags[FLG_LOCK]) begin
            flags <= REG_WDATA[FLAGS_W-1:0];
        end
    end

    // Write-only registers
    always_ff @(posedge MCLK) begin
        if (RST) begin
            probe_sel <= PROBE_RST;
            match_val <= MATCH_RST;
        end else if (wr) begin
            if (offs == ADDR_PROBE_SELECT) begin
                probe_sel <= REG_WDATA[PROBE_W-1:0];
            end
            if (offs == ADDR_POS_MATCH) begin
                match_val <= REG_WDATA;
            end
        end
    end

    // Set wins over read clear; faults clear only once gone
    always_comb begin
        next_status = status;
        if (rd && offs == ADDR_GLOBAL_STATUS) begin
            next_status[STS_RESET] = 1'b0;
            next_status[STS_PUMP_UV] = 1'b0;
            if (!DRV1_SHUTDOWN) begin
                next_status[STS_DRV1] = 1'b0;
            end
            if (!DRV2_SHUTDOWN) begin
                next_status[STS_DRV2] = 1'b0;
            end
        end
        if (DRV1_SHUTDOWN) begin
            next_status[STS_DRV1] = 1'b1;
        end
        if (DRV2_SHUTDOWN) begin
            next_status[STS_DRV2] = 1'b1;
        end
        if (pump_uv) begin
            next_status[STS_PUMP_UV] = 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            status <= STATUS_RST;
        end else begin
            status <= next_status;
        end
    end

    // Read data; write-only and unmapped offsets read zero
    always_ff @(posedge MCLK) begin
        if (RST) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (rd) begin
            REG_RDATA <= 32'h0000_0000;
            case (offs)
                ADDR_GLOBAL_FLAGS: REG_RDATA[FLAGS_W-1:0] <= flags;
                ADDR_GLOBAL_STATUS: REG_RDATA[STATUS_W-1:0] <= status;
                ADDR_INPUT_REV: begin
                    REG_RDATA[INP_DISABLE_PIN] <= dis_level;
                    REG_RDATA[31:INP_REV_LO] <= SILICON_REV;
                end
                default: REG_RDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Compare and tristate outputs
    always_ff @(posedge MCLK) begin
        if (RST) begin
            POS_PULSE_OUT <= 1'b0;
            POS_PULSE_OE_N <= 1'b1;
            EVENT_IRQ_OUT <= 1'b0;
            EVENT_IRQ_OE_N <= 1'b1;
        end else begin
            POS_PULSE_OUT <= pos_hit;
            EVENT_IRQ_OUT <= EVENT_IRQ_IN;
            // Pins float when off; board needs pull-ups
            POS_PULSE_OE_N <= !flags[FLG_CMP_OUT_ON];
            EVENT_IRQ_OE_N <= !flags[FLG_CMP_OUT_ON];
        end
    end

    // Probe routing, direction and driver enable
    always_ff @(posedge MCLK) begin
        if (RST) begin
            REF_SW_R2_OUT <= 1'b0;
            REF_SW_R2_OE_N <= 1'b1;
            REF_SW_R2_LEVEL <= 1'b0;
            MOTOR1_DIR <= 1'b0;
            MOTOR2_DIR <= 1'b0;
            DRIVERS_ENABLE <= 1'b0;
            GLOBAL_FLAGS <= FLAGS_RST;
        end else begin
            REF_SW_R2_OUT <= PROBE_SRC[probe_sel];
            REF_SW_R2_OE_N <= !flags[FLG_PROBE_ON];
            REF_SW_R2_LEVEL <= !flags[FLG_PROBE_ON]
                && ref_level;
            MOTOR1_DIR <= MOTOR1_DIR_IN ^ flags[FLG_M1_INV];
            MOTOR2_DIR <= MOTOR2_DIR_IN ^ flags[FLG_M2_INV];
            DRIVERS_ENABLE <= !pump_uv;
            GLOBAL_FLAGS <= flags;
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);

    a_flags_lock: assert property (
        flags[FLG_LOCK] |=> $stable(flags))
        else $error("locked flags changed");
    a_pulse_off: assert property (
        !flags[FLG_CMP_OUT_ON] |=> POS_PULSE_OE_N && EVENT_IRQ_OE_N)
        else $error("compare outputs driven while off");
    a_pulse_on: assert property (
        flags[FLG_CMP_OUT_ON] |=> !POS_PULSE_OE_N && !EVENT_IRQ_OE_N)
        else $error("compare outputs not driven");
    a_pulse_match: assert property (
        (CUR_POS == $signed(match_val)) |=> POS_PULSE_OUT)
        else $error("pulse low on match");
    a_pulse_miss: assert property (
        (CUR_POS != $signed(match_val)) |=> !POS_PULSE_OUT)
        else $error("pulse high on mismatch");
    a_fault_hold: assert property (
        DRV1_SHUTDOWN |=> status[STS_DRV1]
            ##1 (status[STS_DRV1] || !$past(DRV1_SHUTDOWN)))
        else $error("driver 1 fault lost while active");
    a_fault_two: assert property (
        DRV2_SHUTDOWN |=> status[STS_DRV2])
        else $error("driver 2 fault not set");
    a_status_sticky: assert property (
        status[STS_PUMP_UV] && !(rd && offs == ADDR_GLOBAL_STATUS)
            |=> status[STS_PUMP_UV])
        else $error("undervoltage flag dropped without read");
    a_uv_disable: assert property (
        pump_uv |=> !DRIVERS_ENABLE)
        else $error("drivers enabled during undervoltage");
    a_dir_invert: assert property (
        flags[FLG_M1_INV] |=> MOTOR1_DIR == !$past(MOTOR1_DIR_IN))
        else $error("motor 1 direction not inverted");
    a_reset_clear: assert property (
        rd && offs == ADDR_GLOBAL_STATUS |=> !status[STS_RESET])
        else $error("reset flag survived read");
    a_flags_write: assert property (
        wr && offs == ADDR_GLOBAL_FLAGS && !flags[FLG_LOCK]
            |=> flags == $past(REG_WDATA[FLAGS_W-1:0]))
        else $error("unlocked flags write lost");
    a_probe_drive: assert property (
        flags[FLG_PROBE_ON] |=> !REF_SW_R2_OE_N && !REF_SW_R2_LEVEL)
        else $error("probe pin not driven while probing");
    a_probe_idle: assert property (
        !flags[FLG_PROBE_ON]
            |=> REF_SW_R2_OE_N && REF_SW_R2_LEVEL == $past(ref_level))
        else $error("switch pin not in normal use");
    a_probe_high: assert property (
        PROBE_SRC[probe_sel] |=> REF_SW_R2_OUT)
        else $error("selected probe source high not routed");
    a_probe_low: assert property (
        !PROBE_SRC[probe_sel] |=> !REF_SW_R2_OUT)
        else $error("selected probe source low not routed");
    a_dir_plain: assert property (
        !flags[FLG_M1_INV] |=> MOTOR1_DIR == $past(MOTOR1_DIR_IN))
        else $error("motor 1 direction changed without invert");
    a_dir_two: assert property (
        flags[FLG_M2_INV] |=> MOTOR2_DIR == !$past(MOTOR2_DIR_IN))
        else $error("motor 2 direction not inverted");
    a_dir_plain_two: assert property (
        !flags[FLG_M2_INV] |=> MOTOR2_DIR == $past(MOTOR2_DIR_IN))
        else $error("motor 2 direction changed without invert");
    a_reset_regs: assert property (
        $fell(RST) |-> status == STATUS_RST && flags == FLAGS_RST
            && probe_sel == PROBE_RST && match_val == MATCH_RST)
        else $error("register not at reset value after reset");
    a_fault_one: assert property (
        DRV1_SHUTDOWN |=> status[STS_DRV1])
        else $error("driver 1 fault not set");
    a_fault_clear: assert property (
        rd && offs == ADDR_GLOBAL_STATUS && !DRV1_SHUTDOWN
            |=> !status[STS_DRV1])
        else $error("driver 1 fault survived read after clearing");
    a_uv_flag: assert property (
        pump_uv |=> status[STS_PUMP_UV])
        else $error("undervoltage flag not set");
    a_uv_enable: assert property (
        !pump_uv |=> DRIVERS_ENABLE)
        else $error("drivers disabled without undervoltage");
    a_pin_read: assert property (
        rd && offs == ADDR_INPUT_REV
            |=> REG_RDATA[INP_DISABLE_PIN] == $past(dis_level))
        else $error("disable pin level misread");
    a_rev_read: assert property (
        rd && offs == ADDR_INPUT_REV
            |=> REG_RDATA[31:INP_REV_LO] == SILICON_REV)
        else $error("revision code misread");
    a_status_read: assert property (
        rd && offs == ADDR_GLOBAL_STATUS
            |=> REG_RDATA[STATUS_W-1:0] == $past(status))
        else $error("status misread");
    a_match_write: assert property (
        wr && offs == ADDR_POS_MATCH
            |=> match_val == $past(REG_WDATA))
        else $error("match value write lost");
    a_irq_copy: assert property (
        EVENT_IRQ_IN |=> EVENT_IRQ_OUT)
        else $error("event output not following its source");
endmodule : gcsr_regs

// ### shared/gcsr_pkg.sv
package gcsr_pkg;
    // Register offsets, as sent on the access port for reads
    localparam logic [6:0] ADDR_GLOBAL_FLAGS = 7'h00;
    localparam logic [6:0] ADDR_GLOBAL_STATUS = 7'h01;
    localparam logic [6:0] ADDR_PROBE_SELECT = 7'h03;
    localparam logic [6:0] ADDR_INPUT_REV = 7'h04;
    localparam logic [6:0] ADDR_POS_MATCH = 7'h05;
    // A write carries the offset plus this
    localparam logic [7:0] WRITE_FLAG = 8'h80;
    localparam int WRITE_BIT = 7;

    // Field widths
    localparam int FLAGS_W = 11;
    localparam int STATUS_W = 4;
    localparam int PROBE_W = 4;
    localparam int PROBE_SRC_W = 16;

    // global_flags fields
    localparam int FLG_CMP_OUT_ON = 3;
    localparam int FLG_PROBE_ON = 7;
    localparam int FLG_M1_INV = 8;
    localparam int FLG_M2_INV = 9;
    localparam int FLG_LOCK = 10;

    // global_status fields
    localparam int STS_RESET = 0;
    localparam int STS_DRV1 = 1;
    localparam int STS_DRV2 = 2;
    localparam int STS_PUMP_UV = 3;

    // input_and_revision fields
    localparam int INP_DISABLE_PIN = 7;
    localparam int INP_REV_LO = 24;

    // Reset values
    localparam logic [FLAGS_W-1:0] FLAGS_RST = 11'h000;
    localparam logic [STATUS_W-1:0] STATUS_RST = 4'h1;
    localparam logic [PROBE_W-1:0] PROBE_RST = 4'h0;
    localparam logic [31:0] MATCH_RST = 32'h0000_0000;
    // Arbitrary neutral revision code
    localparam logic [7:0] SILICON_REV = 8'h01;
endpackage : gcsr_pkg

// ### bench/gcsr_host_model.sv
`timescale 1ns/1ps
// Serial framer stand-in: one register access per call
module gcsr_host_model (
    input wire logic MCLK,
    output logic REG_STROBE,
    output logic [7:0] REG_ADDR,
    output logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA
);
    initial begin
        REG_STROBE = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 32'h0000_0000;
    end
    // Unused readback bits are masked by the caller
    task automatic acc(input logic w, input logic [6:0] off,
                       input logic [31:0] d, output logic [31:0] q);
        @(negedge MCLK);
        REG_STROBE = 1'b1;
        REG_ADDR = {w, off};
        REG_WDATA = d;
        @(negedge MCLK);
        q = REG_RDATA;
        REG_STROBE = 1'b0;
        // Released lines flip so stale values never pass
        REG_ADDR = ~REG_ADDR;
        REG_WDATA = ~d;
    endtask : acc
endmodule : gcsr_host_model

// ### bench/test_gcsr_regs.sv
`timescale 1ns/1ps
module test_gcsr_regs;
    import gcsr_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic strobe;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, q;
    logic signed [31:0] cur_pos = 32'sh0;
    logic [15:0] src = 16'ha5c3;
    logic irq_in = 0, ref_in = 0, d1 = 0, d2 = 0, sd1 = 0, sd2 = 0;
    logic uv = 0, dis = 0;
    logic irq_out, irq_oe_n, pp, pp_oe_n, r2_out, r2_oe_n, r2_lvl;
    logic m1, m2, den;
    logic [FLAGS_W-1:0] flags;
    int error_cnt = 0, n_checks = 0, cyc = 0;

    gcsr_regs i_dut (.MCLK(mclk), .RST(rst), .REG_STROBE(strobe),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .CUR_POS(cur_pos), .EVENT_IRQ_IN(irq_in), .EVENT_IRQ_OUT(irq_out),
        .EVENT_IRQ_OE_N(irq_oe_n), .POS_PULSE_OUT(pp),
        .POS_PULSE_OE_N(pp_oe_n), .PROBE_SRC(src), .REF_SW_R2_IN(ref_in),
        .REF_SW_R2_OUT(r2_out), .REF_SW_R2_OE_N(r2_oe_n),
        .REF_SW_R2_LEVEL(r2_lvl), .MOTOR1_DIR_IN(d1), .MOTOR2_DIR_IN(d2),
        .MOTOR1_DIR(m1), .MOTOR2_DIR(m2), .DRV1_SHUTDOWN(sd1),
        .DRV2_SHUTDOWN(sd2), .PUMP_UV_IN(uv), .DRV_DISABLE_PIN(dis),
        .DRIVERS_ENABLE(den), .GLOBAL_FLAGS(flags));
    gcsr_host_model i_host (.MCLK(mclk), .REG_STROBE(strobe),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata));

    initial forever #2.5 mclk = ~mclk;

    // Whole run is under a hundred cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk
    task rd(input logic [6:0] a);
        i_host.acc(1'b0, a, 32'h0, q);
    endtask : rd
    task wr(input logic [6:0] a, input logic [31:0] d);
        i_host.acc(1'b1, a, d, q);
    endtask : wr
    task tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    task t_reset;
        rd(ADDR_GLOBAL_STATUS);
        chk("status", 32'h1, q);
        rd(ADDR_GLOBAL_STATUS);
        chk("status reread", 32'h0, q);
        rd(ADDR_GLOBAL_FLAGS);
        chk("flags", 32'h0, q);
        chk("oe_n", 32'h3, {pp_oe_n, irq_oe_n});
        chk("enable", 32'h1, den);
        chk("flags port", 32'h0, flags);
        rd(ADDR_INPUT_REV);
        chk("readback", {SILICON_REV, 24'h0}, q & 32'hff00_0080);
    endtask : t_reset

    task t_compare;
        wr(ADDR_GLOBAL_FLAGS, 32'h8);
        wr(ADDR_POS_MATCH, 32'hffff_fffb);
        cur_pos = 32'shffff_fffb;
        irq_in = 1'b1;
        tick(2);
        chk("pulse", 32'hc, {irq_out, pp, pp_oe_n, irq_oe_n});
        cur_pos = 32'shffff_fffc;
        tick(1);
        chk("pulse off", 32'h0, pp);
        wr(ADDR_GLOBAL_FLAGS, 32'h0);
        tick(1);
        chk("oe_n off", 32'h3, {pp_oe_n, irq_oe_n});
    endtask : t_compare

    task t_probe;
        ref_in = 1'b1;
        tick(6);
        chk("switch level", 32'h1, r2_lvl);
        wr(ADDR_PROBE_SELECT, 32'h6);
        rd(ADDR_PROBE_SELECT);
        chk("probe select read", 32'h0, q);
        wr(ADDR_GLOBAL_FLAGS, 32'h380);
        d1 = 1'b1;
        tick(2);
        chk("probe dir", 32'h9, {r2_out, r2_oe_n, m1, m2});
        chk("probe level", 32'h0, r2_lvl);
        chk("flags port", 32'h380, flags);
    endtask : t_probe

    task t_faults;
        for (int i = 1; i <= 2; i++) begin
            {sd2, sd1} = 2'(i);
            tick(1);
            rd(ADDR_GLOBAL_STATUS);
            chk("fault", 32'h1 << i, q);
            rd(ADDR_GLOBAL_STATUS);
            chk("fault held", 32'h1 << i, q);
            {sd2, sd1} = 2'b00;
            rd(ADDR_GLOBAL_STATUS);
            chk("fault sticky", 32'h1 << i, q);
            rd(ADDR_GLOBAL_STATUS);
            chk("fault clear", 32'h0, q);
        end
        uv = 1'b1;
        dis = 1'b1;
        tick(6);
        chk("enable", 32'h0, den);
        rd(ADDR_GLOBAL_STATUS);
        chk("uv", 32'h8, q);
        rd(ADDR_INPUT_REV);
        chk("disable pin", 32'h80, q & 32'h80);
        uv = 1'b0;
        tick(6);
        rd(ADDR_GLOBAL_STATUS);
        chk("uv sticky", 32'h8, q);
        rd(ADDR_GLOBAL_STATUS);
        chk("uv clear", 32'h0, q);
    endtask : t_faults

    task t_lock;
        wr(ADDR_GLOBAL_FLAGS, 32'h408);
        wr(ADDR_GLOBAL_FLAGS, 32'h0);
        rd(ADDR_GLOBAL_FLAGS);
        chk("locked", 32'h408, q);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        rd(ADDR_GLOBAL_STATUS);
        chk("reset flag", 32'h1, q);
        rd(ADDR_GLOBAL_FLAGS);
        chk("flags cleared", 32'h0, q);
    endtask : t_lock

    task summarize;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        tick(3);
        rst = 1'b0;
        t_reset();
        t_compare();
        t_probe();
        t_faults();
        t_lock();
        summarize();
    end
endmodule : test_gcsr_regs
